/* File: common/cfg_pkg.sv */
// Shared constants for the serial configuration port and its host.
// Assumes a 250 MHz system clock at both ends of the link.
package cfg_pkg;
    // System clock period and unit scaling.
    localparam int CLK_PERIOD_NS = 4;
    localparam int NS_PER_MS = 1000000;
    // Calibration, erase and program times in milliseconds.
    localparam int CAL_USER_MAX_MS = 100;
    localparam int CAL_PWRUP_MAX_MS = 250;
    localparam int NV_HOLD_MIN_MS = 80;
    localparam int NV_HOLD_MAX_MS = 100;
    localparam int NV_SETTLE_MS = 2;
    // Pin timings in nanoseconds.
    localparam int CAL_PULSE_MIN_NS = 40;
    localparam int TCK_HALF_NS = 100;
    // Longest times round down, least times round up.
    localparam int CAL_USER_CYC = CAL_USER_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int CAL_PWRUP_CYC = CAL_PWRUP_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int NV_HOLD_CYC = (NV_HOLD_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_SETTLE_CYC = NV_SETTLE_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int CAL_PULSE_CYC = (CAL_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Serial control word layout.
    localparam int WORD_W = 8;
    localparam int GAIN_HI_BIT = 7;
    localparam int GAIN_LO_BIT = 6;
    localparam int BANK_BIT = 5;
    localparam int CAL_BIT = 4;
    localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
    // Gain codes.
    localparam logic [1:0] GAIN_1X = 2'h0;
    localparam logic [1:0] GAIN_2X = 2'h1;
    localparam logic [1:0] GAIN_5X = 2'h2;
    localparam logic [1:0] GAIN_10X = 2'h3;
    // Instruction register.
    localparam int IR_W = 3;
    localparam logic [IR_W-1:0] IR_ERASE = 3'h1;
    localparam logic [IR_W-1:0] IR_PROGRAM = 3'h2;
    localparam logic [IR_W-1:0] IR_CFG = 3'h3;
    localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    // Pin positions in the device's synchroniser vector.
    localparam int PIN_TCK = 0;
    localparam int PIN_TMS = 1;
    localparam int PIN_TDI = 2;
    localparam int PIN_CS = 3;
    localparam int PIN_CAL = 4;
    localparam int PIN_MODE = 5;
    localparam int PIN_W = 6;
    // Host scan sequences, sent least significant bit first.
    localparam logic [5:0] PREFIX_TMS = 6'h1f;
    localparam logic [8:0] IR_SCAN_TMS = 9'h0c3;
    localparam logic [12:0] DR_SCAN_TMS = 13'h0c01;
    localparam logic [4:0] RESET_TMS = 5'h1f;
    localparam logic [5:0] SPI_BITS = 6'h08;
    localparam logic [5:0] ERASE_BITS = 6'h0f;
    localparam logic [5:0] PROGRAM_BITS = 6'h25;
    localparam logic [5:0] RESET_BITS = 6'h05;
    // Test access port controller states.
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;
    // Host command codes.
    typedef enum logic [1:0] {OP_SPI, OP_ERASE, OP_PROGRAM, OP_CAL} op_t;
    // Gain code to amplification factor.
    function automatic logic [3:0] gain_factor(input logic [1:0] code);
        unique case (code)
            GAIN_1X: gain_factor = 4'h1;
            GAIN_2X: gain_factor = 4'h2;
            GAIN_5X: gain_factor = 4'h5;
            GAIN_10X: gain_factor = 4'ha;
        endcase
    endfunction
endpackage

/* File: common/link_if.sv */
// Pins between the host controller and the configuration port.
// TDO is pulled high when nobody drives it.
interface link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic cs;
    logic cal;
    logic serial_mode_select;
    logic tdo;
    logic tdo_oe;
    logic tdo_line;
    // Resolved TDO level with a weak pull-up.
    assign tdo_line = tdo_oe ? tdo : 1'b1;
    modport device (input tck, tms, tdi, cs, cal, serial_mode_select, output tdo, tdo_oe);
    modport host (output tck, tms, tdi, cs, cal, serial_mode_select, input tdo_line);
endinterface

/* File: src/config_port_end.sv */
// Device end of the serial configuration port with auto-calibration.
// Assumes all link pins are asynchronous to clock; they are filtered here.
//
// Contract
// - Mode pin high selects latched serial mode.
// - TMS used only in test access mode.
// - TDI taken on TCK rise, word on CS rise.
// - TDO changes on TCK fall or CS rise.
// - CS rise loads shifted word into settings.
// - CAL rising edge runs calibration within 100 ms.
// - Calibration runs after reset within 250 ms.
// - Host holds Run-Test/Idle 80-100 ms programming.
// - Host holds Run-Test/Idle 80-100 ms erasing.
// - Programming erases first, then rewrites stored word.
// - Erase forces ten-times gain in test access mode until rewritten.
// - Host keeps each write a full 80 ms.
// - Word: gain high, gain low, bank, cal, four spare.
// - Gain codes 00/01/10/11 give 1/2/5/10 times.
// - Serial shift register clears to zero at reset.
module config_port_end #(
    parameter int unsigned CAL_USER_CYCLES = cfg_pkg::CAL_USER_CYC,
    parameter int unsigned CAL_PWRUP_CYCLES = cfg_pkg::CAL_PWRUP_CYC,
    parameter int unsigned NV_SETTLE_CYCLES = cfg_pkg::NV_SETTLE_CYC
) (
    // System clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Link pins.
    link_if.device link,
    // Active settings.
    output logic [1:0] gain_code_q,
    output logic [3:0] gain_factor_q,
    output logic bank_b_q,
    // Status.
    output logic cal_busy_q,
    output logic nv_busy_q,
    output logic [cfg_pkg::WORD_W-1:0] nv_word_q
);
    import cfg_pkg::*;

    // Idle pin levels; resetting the filter to them avoids a false chip-select edge after reset.
    localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'((1 << PIN_CS) | (1 << PIN_TMS));
    logic [PIN_W-1:0] pins; // Raw pin levels.
    logic [PIN_W-1:0] s1_q; // First synchroniser stage, read only by s2_q.
    logic [PIN_W-1:0] s2_q; // Second stage.
    logic [PIN_W-1:0] s3_q; // Third stage.
    logic [PIN_W-1:0] f_q; // Filtered pin levels.
    logic [PIN_W-1:0] f_d; // Next filtered levels.
    logic [PIN_W-1:0] rise; // Filtered rising edges.
    logic [PIN_W-1:0] fall; // Filtered falling edges.
    logic serial_mode; // High in latched serial mode.
    logic tck_rise; // TCK rising edge in test access mode.
    logic tck_fall; // TCK falling edge in test access mode.
    logic cs_rise; // CS rising edge in serial mode.
    logic tdi_bit; // TDI level at the sampling edge.
    tap_state_t state_q; // Controller state.
    tap_state_t state_d; // Next controller state.
    logic [IR_W-1:0] ir_sr_q; // Instruction shift stage.
    logic [IR_W-1:0] ir_q; // Current instruction.
    logic [WORD_W-1:0] dr_sr_q; // Data shift stage, bit 0 doubles as bypass.
    logic [WORD_W-1:0] cfg_q; // Word staged for programming.
    logic [WORD_W-1:0] spi_sr_q; // Serial shift register.
    logic [WORD_W-1:0] spi_word_q; // Latched serial word.
    logic erased_q; // Stored word is blank after an erase.
    logic [31:0] nv_cnt_q; // Cycles spent in a programming idle phase.
    logic [31:0] cal_cnt_q; // Calibration cycles left.
    logic cal_req; // Request to start a calibration.
    logic [1:0] gain_d; // Next active gain code.

    assign pins = {link.serial_mode_select, link.cal, link.cs, link.tdi, link.tms, link.tck};

    // Three-stage synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_q <= PIN_IDLE;
            s2_q <= PIN_IDLE;
            s3_q <= PIN_IDLE;
            f_q <= PIN_IDLE;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
        end
    end

    // Agreeing stages set the level, disagreeing ones hold it.
    always_comb begin
        f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));
        rise = f_d & ~f_q;
        fall = ~f_d & f_q;
        serial_mode = f_q[PIN_MODE];
        tck_rise = rise[PIN_TCK] & ~serial_mode;
        tck_fall = fall[PIN_TCK] & ~serial_mode;
        cs_rise = rise[PIN_CS] & serial_mode;
        tdi_bit = f_d[PIN_TDI];
    end

    // Controller next state; TMS is looked at only through tck_rise.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TLR: state_d = f_d[PIN_TMS] ? TLR : RTI;
            RTI: state_d = f_d[PIN_TMS] ? SEL_DR : RTI;
            SEL_DR: state_d = f_d[PIN_TMS] ? SEL_IR : CAP_DR;
            CAP_DR: state_d = f_d[PIN_TMS] ? EX1_DR : SH_DR;
            SH_DR: state_d = f_d[PIN_TMS] ? EX1_DR : SH_DR;
            EX1_DR: state_d = f_d[PIN_TMS] ? UPD_DR : PA_DR;
            PA_DR: state_d = f_d[PIN_TMS] ? EX2_DR : PA_DR;
            EX2_DR: state_d = f_d[PIN_TMS] ? UPD_DR : SH_DR;
            UPD_DR: state_d = f_d[PIN_TMS] ? SEL_DR : RTI;
            SEL_IR: state_d = f_d[PIN_TMS] ? TLR : CAP_IR;
            CAP_IR: state_d = f_d[PIN_TMS] ? EX1_IR : SH_IR;
            SH_IR: state_d = f_d[PIN_TMS] ? EX1_IR : SH_IR;
            EX1_IR: state_d = f_d[PIN_TMS] ? UPD_IR : PA_IR;
            PA_IR: state_d = f_d[PIN_TMS] ? EX2_IR : PA_IR;
            EX2_IR: state_d = f_d[PIN_TMS] ? UPD_IR : SH_IR;
            UPD_IR: state_d = f_d[PIN_TMS] ? SEL_DR : RTI;
        endcase
    end

    // Controller advances only on TCK rises in test access mode.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= TLR;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // Instruction and data scan chains, sampled on TCK rise.
    always_ff @(posedge clock) begin
        if (reset) begin
            ir_sr_q <= IR_CAPTURE;
            ir_q <= IR_BYPASS;
            dr_sr_q <= '0;
            cfg_q <= '0;
        end else if (tck_rise) begin
            unique case (state_q)
                TLR: begin
                    ir_q <= IR_BYPASS;
                end
                CAP_IR: begin
                    ir_sr_q <= IR_CAPTURE;
                end
                SH_IR: begin
                    ir_sr_q <= {tdi_bit, ir_sr_q[IR_W-1:1]};
                end
                UPD_IR: begin
                    ir_q <= ir_sr_q;
                end
                CAP_DR: begin
                    // Only the staging register has content to report.
                    dr_sr_q <= (ir_q == IR_CFG) ? cfg_q : '0;
                end
                SH_DR: begin
                    if (ir_q == IR_CFG) begin
                        dr_sr_q <= {tdi_bit, dr_sr_q[WORD_W-1:1]};
                    end else begin
                        dr_sr_q <= {dr_sr_q[WORD_W-1:1], tdi_bit};
                    end
                end
                UPD_DR: begin
                    if (ir_q == IR_CFG) begin
                        cfg_q <= dr_sr_q;
                    end
                end
                default: begin
                    // Other states leave the chains untouched.
                end
            endcase
        end
    end

    // Serial mode shifts on TCK rise while CS is low; CS rise latches the word.
    always_ff @(posedge clock) begin
        if (reset) begin
            spi_sr_q <= WORD_RESET;
            spi_word_q <= WORD_RESET;
        end else if (serial_mode) begin
            if (rise[PIN_TCK] && !f_q[PIN_CS]) begin
                spi_sr_q <= {tdi_bit, spi_sr_q[WORD_W-1:1]};
            end
            if (cs_rise) begin
                spi_word_q <= spi_sr_q;
            end
        end
    end

    // TDO moves on TCK fall in test access mode and on CS rise in serial mode.
    always_ff @(posedge clock) begin
        if (reset) begin
            link.tdo <= 1'b1;
            link.tdo_oe <= 1'b0;
        end else if (cs_rise) begin
            link.tdo <= spi_sr_q[GAIN_HI_BIT];
            link.tdo_oe <= 1'b1;
        end else if (tck_fall) begin
            link.tdo <= (state_q == SH_IR) ? ir_sr_q[0] : dr_sr_q[0];
            link.tdo_oe <= (state_q == SH_IR) || (state_q == SH_DR);
        end else if (!serial_mode && f_q[PIN_TCK] == 1'b0 && state_q != SH_IR && state_q != SH_DR) begin
            // Float once the controller leaves a shift state.
            link.tdo_oe <= 1'b0;
        end
    end

    // Stored word: erase blanks it, program erases then rewrites after settling.
    // The write lands early but the host must still hold idle for the full time.
    always_ff @(posedge clock) begin
        if (reset) begin
            nv_word_q <= WORD_RESET;
            erased_q <= 1'b0;
            nv_cnt_q <= '0;
            nv_busy_q <= 1'b0;
        end else if (!serial_mode && state_q == RTI && ir_q == IR_ERASE) begin
            nv_word_q <= WORD_RESET;
            erased_q <= 1'b1;
            nv_busy_q <= 1'b1;
        end else if (!serial_mode && state_q == RTI && ir_q == IR_PROGRAM) begin
            nv_busy_q <= 1'b1;
            if (nv_cnt_q < NV_SETTLE_CYCLES - 1) begin
                nv_cnt_q <= nv_cnt_q + 32'h1;
                nv_word_q <= WORD_RESET;
                erased_q <= 1'b1;
            end else if (nv_cnt_q == NV_SETTLE_CYCLES - 1) begin
                nv_cnt_q <= nv_cnt_q + 32'h1;
                nv_word_q <= cfg_q;
                erased_q <= 1'b0;
            end
        end else begin
            // Leaving idle ends the operation; an erase stays in force.
            nv_cnt_q <= '0;
            nv_busy_q <= 1'b0;
        end
    end

    // A calibrate bit in a latched word counts as a request as well.
    assign cal_req = rise[PIN_CAL] | (cs_rise & spi_sr_q[CAL_BIT]);

    // Calibration timer, armed at reset and by requests when idle.
    always_ff @(posedge clock) begin
        if (reset) begin
            cal_busy_q <= 1'b1;
            cal_cnt_q <= CAL_PWRUP_CYCLES - 1;
        end else if (cal_busy_q) begin
            // Requests here are dropped.
            if (cal_cnt_q == 32'h0) begin
                cal_busy_q <= 1'b0;
            end else begin
                cal_cnt_q <= cal_cnt_q - 32'h1;
            end
        end else if (cal_req) begin
            cal_busy_q <= 1'b1;
            cal_cnt_q <= CAL_USER_CYCLES - 1;
        end
    end

    // Active gain: blank store forces ten times outside serial mode, else the mode's source.
    always_comb begin
        if (erased_q && !serial_mode) begin
            gain_d = GAIN_10X;
        end else if (serial_mode) begin
            gain_d = spi_word_q[GAIN_HI_BIT:GAIN_LO_BIT];
        end else begin
            gain_d = nv_word_q[GAIN_HI_BIT:GAIN_LO_BIT];
        end
    end

    // Registered settings outputs.
    always_ff @(posedge clock) begin
        if (reset) begin
            gain_code_q <= GAIN_1X;
            gain_factor_q <= 4'h1;
            bank_b_q <= 1'b0;
        end else begin
            gain_code_q <= gain_d;
            gain_factor_q <= gain_factor(gain_d);
            bank_b_q <= serial_mode ? spi_word_q[BANK_BIT] : nv_word_q[BANK_BIT];
        end
    end
endmodule

/* File: src/config_host_end.sv */
// Host end: drives the link pins to run serial, erase, program and calibrate.
// Assumes the device end filters every pin it receives.
module config_host_end #(
    parameter int unsigned TCK_HALF_CYCLES = cfg_pkg::TCK_HALF_CYC,
    parameter int unsigned NV_HOLD_CYCLES = cfg_pkg::NV_HOLD_CYC,
    parameter int unsigned CAL_PULSE_CYCLES = cfg_pkg::CAL_PULSE_CYC
) (
    // System clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Command port.
    input wire logic cmd_valid,
    input wire cfg_pkg::op_t cmd_op,
    input wire logic [cfg_pkg::WORD_W-1:0] cmd_data,
    output logic cmd_ready_q,
    output logic done_q,
    output logic [cfg_pkg::WORD_W-1:0] rx_word_q,
    // Link pins.
    link_if.host link
);
    import cfg_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_BITS, H_HOLD, H_CAL} host_state_t;

    host_state_t state_q; // Sequencer state.
    logic [63:0] tms_vec_q; // TMS bits still to send, next at bit 0.
    logic [63:0] tdi_vec_q; // TDI bits still to send.
    logic [5:0] nbits_q; // Bits left including the one presented.
    logic hold_q; // Hold idle after the bits.
    logic [31:0] cnt_q; // Divider, hold and pulse counter.
    logic [2:0] tdo_s_q; // TDO synchroniser stages.
    logic tdo_f_q; // Filtered TDO.

    // Scan of an instruction, with entry from and return to idle.
    function automatic logic [8:0] ir_tdi(input logic [IR_W-1:0] ir);
        ir_tdi = {2'b00, ir, 4'h0};
    endfunction

    // Scan of a data word, with entry from and return to idle.
    function automatic logic [12:0] dr_tdi(input logic [WORD_W-1:0] d);
        dr_tdi = {2'b00, d, 3'b000};
    endfunction

    // TDO synchroniser; stage one feeds only stage two.
    always_ff @(posedge clock) begin
        if (reset) begin
            tdo_s_q <= 3'h7;
            tdo_f_q <= 1'b1;
        end else begin
            tdo_s_q <= {tdo_s_q[1:0], link.tdo_line};
            if (tdo_s_q[1] == tdo_s_q[2]) begin
                tdo_f_q <= tdo_s_q[1];
            end
        end
    end

    // Command sequencer and pin drivers.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= H_IDLE;
            tms_vec_q <= '0;
            tdi_vec_q <= '0;
            nbits_q <= '0;
            hold_q <= 1'b0;
            cnt_q <= '0;
            cmd_ready_q <= 1'b1;
            done_q <= 1'b0;
            rx_word_q <= '0;
            link.tck <= 1'b0;
            link.tms <= 1'b1;
            link.tdi <= 1'b0;
            link.cs <= 1'b1;
            link.cal <= 1'b0;
            link.serial_mode_select <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                H_IDLE: begin
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        cnt_q <= '0;
                        state_q <= H_BITS;
                        hold_q <= (cmd_op == OP_ERASE) || (cmd_op == OP_PROGRAM);
                        link.serial_mode_select <= (cmd_op == OP_SPI);
                        unique case (cmd_op)
                            OP_SPI: begin
                                // Least significant bit first; CS falls here.
                                tdi_vec_q <= {56'h0, cmd_data};
                                tms_vec_q <= '0;
                                nbits_q <= SPI_BITS;
                                link.tdi <= cmd_data[0];
                                link.cs <= 1'b0;
                            end
                            OP_ERASE: begin
                                tms_vec_q <= {49'h0, IR_SCAN_TMS, PREFIX_TMS};
                                tdi_vec_q <= {49'h0, ir_tdi(IR_ERASE), 6'h00};
                                nbits_q <= ERASE_BITS;
                                link.tms <= PREFIX_TMS[0];
                                link.tdi <= 1'b0;
                            end
                            OP_PROGRAM: begin
                                // Stage the word, then start the program cycle.
                                tms_vec_q <= {27'h0, IR_SCAN_TMS, DR_SCAN_TMS, IR_SCAN_TMS, PREFIX_TMS};
                                tdi_vec_q <= {27'h0, ir_tdi(IR_PROGRAM), dr_tdi(cmd_data), ir_tdi(IR_CFG), 6'h00};
                                nbits_q <= PROGRAM_BITS;
                                link.tms <= PREFIX_TMS[0];
                                link.tdi <= 1'b0;
                            end
                            OP_CAL: begin
                                link.cal <= 1'b1;
                                state_q <= H_CAL;
                            end
                        endcase
                    end
                end
                H_BITS: begin
                    if (cnt_q == TCK_HALF_CYCLES - 1) begin
                        cnt_q <= '0;
                        if (!link.tck) begin
                            link.tck <= 1'b1;
                            rx_word_q <= {tdo_f_q, rx_word_q[WORD_W-1:1]};
                        end else begin
                            link.tck <= 1'b0;
                            tms_vec_q <= tms_vec_q >> 1;
                            tdi_vec_q <= tdi_vec_q >> 1;
                            link.tms <= tms_vec_q[1];
                            link.tdi <= tdi_vec_q[1];
                            nbits_q <= nbits_q - 6'h1;
                            if (nbits_q == 6'h1) begin
                                link.cs <= 1'b1;
                                state_q <= hold_q ? H_HOLD : H_IDLE;
                                cmd_ready_q <= !hold_q;
                                done_q <= !hold_q;
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                H_HOLD: begin
                    // TCK stands low so the device stays in idle.
                    if (cnt_q == NV_HOLD_CYCLES - 1) begin
                        cnt_q <= '0;
                        hold_q <= 1'b0;
                        tms_vec_q <= {59'h0, RESET_TMS};
                        tdi_vec_q <= '0;
                        nbits_q <= RESET_BITS;
                        link.tms <= RESET_TMS[0];
                        state_q <= H_BITS;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                H_CAL: begin
                    if (cnt_q == CAL_PULSE_CYCLES - 1) begin
                        link.cal <= 1'b0;
                        cmd_ready_q <= 1'b1;
                        done_q <= 1'b1;
                        state_q <= H_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
            endcase
        end
    end
endmodule

/* File: testbench/link_checker_sva.sv */
// Concurrent checks on the pins of the link between host and device.
// Assumes one 250 MHz clock and a synchronous active high reset.
module link_checker (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Link pins.
    input wire logic tck,
    input wire logic cs,
    input wire logic cal,
    input wire logic serial_mode_select,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic tdo_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tck_q; // Last sampled test clock.
    logic [3:0] bits_q; // Clock rises seen in the current serial frame.
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Counts bits of one frame; the count still stands on the cycle the frame ends.
    always_ff @(posedge clock) begin
        tck_q <= tck;
        if (reset || cs) begin
            bits_q <= 4'h0;
        end else if (tck && !tck_q) begin
            bits_q <= bits_q + 4'h1;
        end
    end
    // A calibrate pulse must pass the filter and then be released.
    sequence cal_hold_s;
        cal [*8] ##[1:20] !cal;
    endsequence
    serial_select_a: assert property (!cs |-> serial_mode_select) else $error("select low outside serial mode");
    word_length_a: assert property ($rose(cs) |-> bits_q == 4'h8) else $error("frame not eight bits");
    clock_idle_a: assert property (serial_mode_select && cs |-> !tck) else $error("clock runs between frames");
    clock_high_a: assert property ($rose(tck) |-> tck [*8]) else $error("clock high time short");
    cal_pulse_a: assert property ($rose(cal) |-> cal_hold_s) else $error("calibrate pulse wrong");
    tap_tdo_a: assert property (!serial_mode_select && !$past(serial_mode_select, 8) && tdo_oe && $past(tdo_oe)
        && $changed(tdo) |-> !tck) else $error("data out moved while clock high");
    spi_tdo_a: assert property (serial_mode_select && $past(serial_mode_select, 8) && $changed(tdo) |-> cs)
        else $error("data out moved inside frame");
    spi_drive_a: assert property (serial_mode_select && $past(serial_mode_select, 8) && $past(tdo_oe) |->
        tdo_oe && tdo_line == tdo) else $error("data out released in serial mode");
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench: host end and device end joined by the link.
// Assumes shortened calibration and settle counts given below.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cfg_pkg::*;
    localparam int CAL_U = 200;
    localparam int CAL_P = 300;
    localparam logic [3:0] FACT [4] = '{4'h1, 4'h2, 4'h5, 4'ha};
    logic clock, reset, cmd_valid, cmd_ready_q, done_q, cal_busy_q, nv_busy_q, bank_b_q, seen_10x = 1'b0;
    op_t cmd_op;
    logic [7:0] cmd_data, nv_word_q, rx_word_q;
    logic [1:0] gain_code_q;
    logic [3:0] gain_factor_q;
    int fails, checks_done, n;
    link_if link ();
    config_port_end #(.CAL_USER_CYCLES(CAL_U), .CAL_PWRUP_CYCLES(CAL_P), .NV_SETTLE_CYCLES(20)) u_config_port_end (
        .clock(clock), .reset(reset), .link(link), .gain_code_q(gain_code_q), .gain_factor_q(gain_factor_q),
        .bank_b_q(bank_b_q), .cal_busy_q(cal_busy_q), .nv_busy_q(nv_busy_q), .nv_word_q(nv_word_q));
    config_host_end #(.NV_HOLD_CYCLES(100)) u_config_host_end (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready_q(cmd_ready_q), .done_q(done_q), .rx_word_q(rx_word_q),
        .link(link));
    link_checker u_link_checker (.clock(clock), .reset(reset), .tck(link.tck), .cs(link.cs), .cal(link.cal),
        .serial_mode_select(link.serial_mode_select), .tdo(link.tdo), .tdo_oe(link.tdo_oe), .tdo_line(link.tdo_line));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Notes whether a write hold ever showed the blank store's gain.
    always @(posedge clock) if (nv_busy_q && gain_code_q === GAIN_10X) seen_10x <= 1'b1;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One host command, then time for the pin filters to settle.
    task automatic run(input op_t op, input logic [7:0] d);
        @(negedge clock);
        cmd_op = op;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        for (n = 0; done_q !== 1'b1 && n < 9000; n++) @(negedge clock);
        chk("done", 8'h03, {6'h00, cmd_ready_q, done_q});
        repeat (8) @(negedge clock);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = OP_SPI;
        cmd_data = 8'h00;
        repeat (20) @(negedge clock);
        reset = 1'b0;
        chk("gain", GAIN_1X, gain_code_q);
        chk("bank", 8'h00, bank_b_q);
        chk("store", 8'h00, nv_word_q);
        chk("cal_busy", 8'h01, cal_busy_q);
        for (n = 0; cal_busy_q === 1'b1 && n < 400; n++) @(negedge clock);
        chk("pwrup_time", 8'h01, n <= CAL_P + 1);
        $display("test reset done");
        for (int g = 0; g < 4; g++) begin
            run(OP_SPI, {g[1:0], g[0], 5'h00});
            chk("gain", g[1:0], gain_code_q);
            chk("factor", FACT[g], gain_factor_q);
            chk("bank", g[0], bank_b_q);
            // Each frame reads the previous word's gain-high bit; the first one reads the pull-up.
            chk("tdo_word", (g == 0 || g - 1 >= 2) ? 8'hff : 8'h00, rx_word_q);
        end
        $display("test gains done");
        // The second request lands mid-run and must not stretch it.
        run(OP_CAL, 8'h00);
        chk("cal_start", 8'h01, cal_busy_q);
        run(OP_CAL, 8'h00);
        for (n = 0; cal_busy_q === 1'b1 && n < 400; n++) @(negedge clock);
        chk("cal_time", 8'h01, n <= CAL_U - 20);
        run(OP_SPI, 8'h10);
        chk("word_cal", 8'h01, cal_busy_q);
        $display("test calibrate done");
        run(OP_PROGRAM, 8'h60);
        chk("prog_store", 8'h60, nv_word_q);
        chk("prog_gain", GAIN_2X, gain_code_q);
        chk("blank_first", 8'h01, seen_10x);
        run(OP_ERASE, 8'h00);
        chk("erase_gain", GAIN_10X, gain_code_q);
        chk("erase_store", 8'h00, nv_word_q);
        $display("test store done");
        test_done;
    end
    // About three times the expected run length.
    initial begin
        #80000;
        fails++;
        test_done;
    end
endmodule
